// *** bench/ssiu_host.sv ***
// host cpu: one bus transfer at a time, each wait bounded
module ssiu_host (
   // clock
   input wire logic i_clk,
   // write channels
   output logic [5:0] o_awaddr,
   output logic o_awvalid,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   output logic o_bready,
   input wire logic i_awready,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   // read channels
   output logic [5:0] o_araddr,
   output logic o_arvalid,
   output logic o_rready,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   // raised when the slave never answers
   output logic o_hang
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready, o_hang} = '0;
   // software write: only these change page bits or ack requests
   task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge i_clk);
      {o_awaddr, o_wdata, o_wstrb} <= {a, 24'h0, d, 4'hF};
      {o_awvalid, o_wvalid, o_bready} <= 3'h7;
      do begin
         @(posedge i_clk);
         n++;
         if (i_awready) o_awvalid <= 1'b0;
         if (i_wready) o_wvalid <= 1'b0;
      end while (!i_bvalid && n < 50);
      r = i_bresp;
      o_bready <= 1'b0;
      if (n >= 50) o_hang <= 1'b1;
   endtask
   // software read: a code read may start the tx fifo hold
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge i_clk);
      o_araddr <= a;
      {o_arvalid, o_rready} <= 2'h3;
      do begin
         @(posedge i_clk);
         n++;
         if (i_arready) o_arvalid <= 1'b0;
      end while (!i_rvalid && n < 50);
      {d, r} = {i_rdata[7:0], i_rresp};
      o_rready <= 1'b0;
      if (n >= 50) o_hang <= 1'b1;
   endtask
endmodule

// *** bench/ssiu_props.sv ***
module ssiu_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // bus handshakes and answers
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [5:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // device outputs
   input wire logic o_irq,
   input wire logic [1:0] o_register_page_select
);
   default clocking dc @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // accepted read, and one aimed past the last register
   sequence rd_taken;
      i_arvalid && o_arready;
   endsequence
   sequence rd_unmapped;
      rd_taken ##0 (i_araddr > 6'h2F);
   endsequence
   // address and data offered together, taken together
   sequence wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   read_answer_a: assert property (rd_taken |=> o_rvalid && !o_arready)
      else $error("read not answered");
   unmapped_read_a: assert property (rd_unmapped |=> o_rresp == 2'h2 && o_rdata == 32'h0)
      else $error("unmapped read not refused");
   write_answer_a: assert property (wr_taken |-> ##[1:2] o_bvalid)
      else $error("write not answered");
   bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped early");
   upper_zero_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("register wider than a byte");
   page_by_write_a: assert property ($changed(o_register_page_select) |-> o_bvalid || $past(o_bvalid))
      else $error("page moved without a write");
   irq_after_reset_a: assert property ($rose(i_reset_n) |-> !o_irq && o_register_page_select == 2'h0)
      else $error("irq or page set out of reset");
endmodule

bind ssiu_top ssiu_props u_props (.*);

// *** bench/testbench.sv ***
`include "ssiu_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [5:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0] i_wstrb;
   logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, o_register_page_select, rr;
   logic o_irq, hang;
   logic [7:0] rv;
   // single-cycle event strobes, one bit each
   logic [6:0] pl = 7'h00;
   wire i_overrun = pl[0], i_break_detect = pl[1], i_timer_a_tc = pl[2], i_tx_char_write = pl[3];
   wire i_char_load = pl[4], i_break_end = pl[5], i_timer_b_tc = pl[6];
   logic [2:0] i_rx_fifo_count = 3'h0, i_tx_fifo_count = 3'h0, i_rx_thresh = 3'h0, i_tx_thresh = 3'h0;
   logic [2:0] i_pin_direction_config = 3'h7;
   logic [8:0] i_char_data = 9'h000, i_match_char_zero = 9'h1FF, i_match_char_one = 9'h055;
   logic i_tx_idle_state = 1'b0, i_rx_fifo_read = 1'b0, i_char_len9 = 1'b0, i_char_frame_err = 1'b0;
   logic i_char_parity_err = 1'b0, i_char_parity_bit = 1'b0, i_char_noisy = 1'b0, i_char_is_addr = 1'b0;
   logic i_char_is_std_ctrl = 1'b0, i_char_break = 1'b0, i_char_first_break = 1'b0;
   logic i_multidrop_address_mode = 1'b0, i_sw_parity_mode = 1'b0, i_sample_16x = 1'b1;
   logic i_gate_a_state = 1'b0, i_gate_b_state = 1'b0;
   logic i_cts_pin = 1'b1, i_dsr_pin = 1'b1, i_ri_pin = 1'b1, i_dcd_pin = 1'b1;
   int mismatches = 0;
   int n_tests = 0;
   ssiu_top dut (.*);
   ssiu_host host (.i_clk(i_clk), .o_awaddr(i_awaddr), .o_awvalid(i_awvalid), .o_wdata(i_wdata),
      .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .o_bready(i_bready), .i_awready(o_awready), .i_wready(o_wready),
      .i_bresp(o_bresp), .i_bvalid(o_bvalid), .o_araddr(i_araddr), .o_arvalid(i_arvalid), .o_rready(i_rready),
      .i_arready(o_arready), .i_rdata(o_rdata), .i_rresp(o_rresp), .i_rvalid(o_rvalid), .o_hang(hang));
   initial forever #50 i_clk = ~i_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge i_clk) pl <= m;
      @(posedge i_clk) pl <= 7'h00;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      host.rd(a, rv, rr);
      `CHK(rv, e)
   endtask
   task automatic wrc(input logic [5:0] a, input logic [7:0] d);
      host.wr(a, d, rr);
      `CHK(rr, `SSIU_OKAY)
   endtask
   // idle device, and refusal of addresses past the map
   task automatic t_reset;
      rdc(`SSIU_A_CODE, 8'h01);
      `CHK(o_irq, 1'b0)
      host.rd(6'h30, rv, rr);
      `CHK(rr, `SSIU_SLVERR)
      host.wr(6'h34, 8'hFF, rr);
      `CHK(rr, `SSIU_SLVERR)
      $display("test reset done");
   endtask
   // requests show unmasked; timer then pre-empts tx machine
   task automatic t_prio;
      @(posedge i_clk) {i_tx_idle_state, i_gate_a_state} <= 2'h3;
      rdc(`SSIU_A_REQ, 8'h12);
      `CHK(o_irq, 1'b0)
      wrc(`SSIU_A_TMEN, 8'h03);
      wrc(`SSIU_A_RXEN, 8'hFE);
      wrc(`SSIU_A_GEN, 8'h3F);
      tick(3);
      `CHK(o_irq, 1'b1)
      rdc(`SSIU_A_CODE, 8'h08);
      pulse(7'h44);
      tick(3);
      rdc(`SSIU_A_CODE, 8'h0A);
      rdc(`SSIU_A_TIMER_STATUS, 8'h07);
      rdc(`SSIU_A_TIMER_STATUS, 8'h04);
      tick(3);
      rdc(`SSIU_A_CODE, 8'h08);
      $display("test priority done");
   endtask
   // rx fifo request strictly above threshold, forced low, acked
   task automatic t_rxfifo;
      @(posedge i_clk) {i_tx_idle_state, i_tx_fifo_count, i_rx_thresh, i_rx_fifo_count} <= {1'b0, 9'h112};
      rdc(`SSIU_A_REQ, 8'h00);
      @(posedge i_clk) i_rx_fifo_count <= 3'h3;
      rdc(`SSIU_A_REQ, 8'h04);
      rdc(`SSIU_A_CODE, 8'h04);
      rdc(`SSIU_A_LVL, 8'h43);
      @(posedge i_clk) i_rx_fifo_read <= 1'b1;
      rdc(`SSIU_A_REQ, 8'h00);
      @(posedge i_clk) i_rx_fifo_read <= 1'b0;
      rdc(`SSIU_A_REQ, 8'h04);
      wrc(`SSIU_A_LINE, 8'h00);
      rdc(`SSIU_A_REQ, 8'h00);
      $display("test rx fifo done");
   endtask
   // reading the tx fifo code silences it until a character is written
   task automatic t_hold;
      @(posedge i_clk) {i_rx_fifo_count, i_tx_thresh, i_tx_fifo_count} <= 9'h009;
      rdc(`SSIU_A_REQ, 8'h02);
      rdc(`SSIU_A_CODE, 8'h02);
      tick(3);
      `CHK(o_irq, 1'b0)
      rdc(`SSIU_A_REQ, 8'h02);
      pulse(7'h08);
      tick(3);
      `CHK(o_irq, 1'b1)
      @(posedge i_clk) i_tx_fifo_count <= 3'h2;
      tick(2);
      #10;
      `CHK(o_irq, 1'b1)
      tick(2);
      `CHK(o_irq, 1'b0)
      rdc(`SSIU_A_CODE, 8'h03);
      $display("test tx hold done");
   endtask
   // a broken nine-bit control character, then a clean one
   task automatic t_rxm;
      @(posedge i_clk) {i_char_data, i_char_len9, i_char_frame_err, i_char_noisy} <= 12'hFFF;
      {i_char_is_std_ctrl, i_char_break, i_char_first_break} <= 3'h7;
      pulse(7'h13);
      rdc(`SSIU_A_CHF, 8'h7A);
      rdc(`SSIU_A_CODE, 8'h06);
      rdc(`SSIU_A_LINE, 8'h1A);
      rdc(`SSIU_A_RXST, 8'h00);
      @(posedge i_clk) {i_char_data, i_char_len9, i_char_frame_err, i_char_noisy} <= 12'h0410;
      {i_char_is_std_ctrl, i_char_break, i_char_first_break} <= 3'h0;
      pulse(7'h30);
      rdc(`SSIU_A_CHF, 8'h01);
      rdc(`SSIU_A_RXST, 8'h20);
      rdc(`SSIU_A_RXST, 8'h00);
      $display("test rx machine done");
   endtask
   // multidrop address match, software parity, 1x sampling
   task automatic t_modes;
      @(posedge i_clk) {i_multidrop_address_mode, i_sw_parity_mode, i_sample_16x} <= 3'h6;
      {i_char_data, i_char_is_addr, i_char_parity_err, i_char_parity_bit, i_char_noisy} <= 13'h055F;
      pulse(7'h10);
      rdc(`SSIU_A_CHF, 8'h0D);
      rdc(`SSIU_A_RXST, 8'hC0);
      @(posedge i_clk) {i_multidrop_address_mode, i_sw_parity_mode, i_sample_16x} <= 3'h1;
      $display("test modes done");
   endtask
   // ring delta only on its falling edge, cts on both
   task automatic t_modem;
      host.rd(`SSIU_A_MDST, rv, rr);
      wrc(`SSIU_A_MDEN, 8'h0F);
      @(posedge i_clk) {i_ri_pin, i_cts_pin} <= 2'h0;
      tick(6);
      rdc(`SSIU_A_CODE, 8'h00);
      rdc(`SSIU_A_MDST, 8'h55);
      @(posedge i_clk) {i_ri_pin, i_cts_pin} <= 2'h3;
      tick(6);
      rdc(`SSIU_A_MDST, 8'h01);
      @(posedge i_clk) {i_pin_direction_config, i_dsr_pin} <= 4'hC;
      tick(6);
      rdc(`SSIU_A_MDST, 8'h00);
      $display("test modem done");
   endtask
   // only the page bits of the code register take a write
   task automatic t_page;
      wrc(`SSIU_A_CODE, 8'hFF);
      `CHK(o_register_page_select, 2'h3)
      rdc(`SSIU_A_CODE, 8'h61);
      $display("test page done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge hang) begin
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_reset;
      t_prio;
      t_rxfifo;
      t_hold;
      t_rxm;
      t_modes;
      t_modem;
      t_page;
      tally_and_finish;
   end
endmodule

// *** common/ssiu_defines.vh ***
`ifndef SSIU_DEFINES_VH
`define SSIU_DEFINES_VH
// register byte addresses
`define SSIU_A_REQ 6'h00
`define SSIU_A_GEN 6'h04
`define SSIU_A_CODE 6'h08
`define SSIU_A_LINE 6'h0C
`define SSIU_A_RXST 6'h10
`define SSIU_A_CHF 6'h14
`define SSIU_A_LVL 6'h18
`define SSIU_A_TIMER_STATUS 6'h1C
`define SSIU_A_MDST 6'h20
`define SSIU_A_RXEN 6'h24
`define SSIU_A_TMEN 6'h28
`define SSIU_A_MDEN 6'h2C
// request / enable bit positions
`define SSIU_B_MODEM 0
`define SSIU_B_TXF 1
`define SSIU_B_RXF 2
`define SSIU_B_RXM 3
`define SSIU_B_TXM 4
`define SSIU_B_TIM 5
// priority codes
`define SSIU_C_TIM 3'h5
`define SSIU_C_TXM 3'h4
`define SSIU_C_RXM 3'h3
`define SSIU_C_RXF 3'h2
`define SSIU_C_TXF 3'h1
`define SSIU_C_MODEM 3'h0
// axi responses
`define SSIU_OKAY 2'h0
`define SSIU_SLVERR 2'h2
`endif

// *** logic/ssiu_top.v ***
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`include "ssiu_defines.vh"
module ssiu_top (
   // clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // axi4-lite write
   input wire [5:0] i_awaddr,
   input wire i_awvalid,
   output reg o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   // axi4-lite read
   input wire [5:0] i_araddr,
   input wire i_arvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // fifo and transmitter state
   input wire [2:0] i_rx_fifo_count,
   input wire [2:0] i_tx_fifo_count,
   input wire [2:0] i_rx_thresh,
   input wire [2:0] i_tx_thresh,
   input wire i_tx_idle_state,
   input wire i_rx_fifo_read,
   input wire i_tx_char_write,
   // receive machine events
   input wire i_char_load,
   input wire [8:0] i_char_data,
   input wire i_char_len9,
   input wire i_char_frame_err,
   input wire i_char_parity_err,
   input wire i_char_parity_bit,
   input wire i_char_noisy,
   input wire i_char_is_addr,
   input wire i_char_is_std_ctrl,
   input wire i_char_break,
   input wire i_char_first_break,
   input wire i_break_detect,
   input wire i_break_end,
   input wire i_overrun,
   input wire i_multidrop_address_mode,
   input wire i_sw_parity_mode,
   input wire i_sample_16x,
   input wire [8:0] i_match_char_zero,
   input wire [8:0] i_match_char_one,
   // timers
   input wire i_timer_a_tc,
   input wire i_timer_b_tc,
   input wire i_gate_a_state,
   input wire i_gate_b_state,
   // modem pins (asynchronous) and pin direction config
   input wire i_cts_pin,
   input wire i_dsr_pin,
   input wire i_ri_pin,
   input wire i_dcd_pin,
   input wire [2:0] i_pin_direction_config,
   // outputs to the device
   output reg o_irq,
   output reg [1:0] o_register_page_select
);

   // request register and enables
   reg [5:0] general_block_request_reg;
   reg [5:0] general_enable_reg;
   reg [7:0] rx_enable_reg;
   reg [1:0] timer_enable_reg;
   reg [3:0] modem_enable_reg;
   // code register pieces
   reg [2:0] priority_code_reg;
   reg irq_waiting_n_reg;
   reg tx_hold_reg; // tx fifo interrupt suppressed
   reg [5:0] gated_reg; // enabled requests, one clock behind the request register
   // status registers
   reg [7:1] rx_status_reg; // bit 0 is the live fifo request
   reg [6:0] char_flags_reg;
   reg [3:0] timer_status_reg;
   reg [3:0] modem_delta_reg;
   reg rx_fifo_request_ack_reg; // software acknowledged rx fifo level
   // modem synchronisers: first stage read only by second
   reg [3:0] mdm_s1_reg;
   reg [3:0] mdm_s2_reg;
   reg [3:0] mdm_prev_reg;
   // axi state
   reg [5:0] aw_addr_reg;
   reg aw_got_reg;
   reg [7:0] w_data_reg;
   reg w_strb_reg;
   reg w_got_reg;

   // decoded accesses
   wire rd_take = i_arvalid & o_arready;
   wire wr_do = aw_got_reg & w_got_reg & ~o_bvalid;
   wire wr_b0 = wr_do & w_strb_reg;
   wire rd_code = rd_take & (i_araddr == `SSIU_A_CODE);
   wire rd_line = rd_take & (i_araddr == `SSIU_A_LINE);
   wire rd_rxst = rd_take & (i_araddr == `SSIU_A_RXST);
   wire rd_timer_status = rd_take & (i_araddr == `SSIU_A_TIMER_STATUS);
   wire rd_mdst = rd_take & (i_araddr == `SSIU_A_MDST);
   wire wr_line = wr_b0 & (aw_addr_reg == `SSIU_A_LINE);
   wire wr_rxst = wr_b0 & (aw_addr_reg == `SSIU_A_RXST);
   wire wr_gen = wr_b0 & (aw_addr_reg == `SSIU_A_GEN);

   // modem pins: complement when configured as input
   wire [3:0] mdm_in = {i_pin_direction_config[2], i_pin_direction_config[1], i_pin_direction_config[0], 1'b1};
   wire [3:0] mdm_inv = ~mdm_s2_reg & mdm_in;
   wire [3:0] mdm_chg = (mdm_s2_reg ^ mdm_prev_reg) & mdm_in;
   // bit order dcd, ri, dsr, cts; ring sets only when the pin falls
   wire [3:0] mdm_set = {mdm_chg[3], mdm_prev_reg[2] & ~mdm_s2_reg[2] & mdm_in[2], mdm_chg[1:0]};

   // rx fifo level request, dropped during reads and after ack
   wire rx_above = i_rx_fifo_count > i_rx_thresh;
   wire rx_fifo_request = rx_above & ~rx_fifo_request_ack_reg & ~i_rx_fifo_read;
   wire rx_fifo_request_ack_wr = (wr_line | wr_rxst) & ~w_data_reg[0];

   // character classification
   wire ctl_seen = i_multidrop_address_mode ? i_char_is_addr : i_char_is_std_ctrl;
   wire match_hit = (i_char_data == i_match_char_zero) | (i_char_data == i_match_char_one);
   wire match_ok = match_hit & (~i_multidrop_address_mode | i_char_is_addr);
   wire frame_flag = i_char_frame_err | i_char_first_break;

   // sticky receive status event sets, bits 7..1
   wire [7:1] rx_set = {
      i_char_load & ctl_seen,
      i_char_load & match_ok,
      i_break_end,
      i_break_detect,
      i_char_load & frame_flag,
      i_char_load & i_char_parity_err & ~i_sw_parity_mode,
      i_overrun
   };

   // block-level request terms before the general enables
   wire rxm_req = |(rx_status_reg & rx_enable_reg[7:1]);
   wire tim_req = |(timer_status_reg[1:0] & timer_enable_reg);
   wire mdm_req = |(modem_delta_reg & modem_enable_reg);
   wire txf_req = i_tx_fifo_count <= i_tx_thresh;

   // general enables gate what reaches the code; hold hides tx fifo
   wire [5:0] gated = general_block_request_reg & general_enable_reg &
                      ~({5'h00, tx_hold_reg} << `SSIU_B_TXF);

   // highest-priority enabled source
   reg [2:0] code_next;
   always @* begin
      code_next = priority_code_reg;
      if (gated_reg[`SSIU_B_TIM]) begin
         code_next = `SSIU_C_TIM;
      end else if (gated_reg[`SSIU_B_TXM]) begin
         code_next = `SSIU_C_TXM;
      end else if (gated_reg[`SSIU_B_RXM]) begin
         code_next = `SSIU_C_RXM;
      end else if (gated_reg[`SSIU_B_RXF]) begin
         code_next = `SSIU_C_RXF;
      end else if (gated_reg[`SSIU_B_TXF]) begin
         code_next = `SSIU_C_TXF;
      end else if (gated_reg[`SSIU_B_MODEM]) begin
         code_next = `SSIU_C_MODEM;
      end
   end

   // register read multiplexer
   reg [7:0] rd_val;
   reg rd_hit;
   always @* begin
      rd_hit = 1'b1;
      case (i_araddr)
         `SSIU_A_REQ: rd_val = {2'h0, general_block_request_reg};
         `SSIU_A_GEN: rd_val = {2'h0, general_enable_reg};
         `SSIU_A_CODE: rd_val = {1'b0, o_register_page_select, 1'b0, priority_code_reg, irq_waiting_n_reg};
         `SSIU_A_LINE: rd_val = {1'b0, i_tx_idle_state, txf_req, rx_status_reg[4:1], rx_fifo_request};
         `SSIU_A_RXST: rd_val = {rx_status_reg, rx_fifo_request};
         `SSIU_A_CHF: rd_val = {1'b0, char_flags_reg};
         `SSIU_A_LVL: rd_val = {1'b0, i_tx_fifo_count, 1'b0, i_rx_fifo_count};
         `SSIU_A_TIMER_STATUS: rd_val = {4'h0, timer_status_reg};
         `SSIU_A_MDST: rd_val = {mdm_inv, modem_delta_reg};
         `SSIU_A_RXEN: rd_val = rx_enable_reg;
         `SSIU_A_TMEN: rd_val = {6'h00, timer_enable_reg};
         `SSIU_A_MDEN: rd_val = {4'h0, modem_enable_reg};
         default: begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // axi slave handshakes; one write and one read in flight
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `SSIU_OKAY;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `SSIU_OKAY;
         aw_addr_reg <= 6'h00;
         aw_got_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
         w_got_reg <= 1'b0;
      end else begin
         // address and data taken in either order
         if (i_awvalid && o_awready) begin
            aw_addr_reg <= {i_awaddr[5:2], 2'h0};
            aw_got_reg <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_data_reg <= i_wdata[7:0];
            w_strb_reg <= i_wstrb[0];
            w_got_reg <= 1'b1;
            o_wready <= 1'b0;
         end
         // response once both halves are held
         if (wr_do) begin
            o_bvalid <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            case (aw_addr_reg)
               `SSIU_A_GEN, `SSIU_A_CODE, `SSIU_A_LINE, `SSIU_A_RXST,
               `SSIU_A_RXEN, `SSIU_A_TMEN, `SSIU_A_MDEN: o_bresp <= `SSIU_OKAY;
               default: o_bresp <= `SSIU_SLVERR;
            endcase
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
         // read data captured before any clear-on-read
         if (rd_take) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h000000, rd_val};
            o_rresp <= rd_hit ? `SSIU_OKAY : `SSIU_SLVERR;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // writable control: enables and page bits
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         general_enable_reg <= 6'h00;
         rx_enable_reg <= 8'h00;
         timer_enable_reg <= 2'h0;
         modem_enable_reg <= 4'h0;
         o_register_page_select <= 2'h0;
      end else if (wr_b0) begin
         case (aw_addr_reg)
            `SSIU_A_GEN: general_enable_reg <= w_data_reg[5:0];
            `SSIU_A_CODE: o_register_page_select <= w_data_reg[6:5];
            `SSIU_A_RXEN: rx_enable_reg <= w_data_reg;
            `SSIU_A_TMEN: timer_enable_reg <= w_data_reg[1:0];
            `SSIU_A_MDEN: modem_enable_reg <= w_data_reg[3:0];
            default: ;
         endcase
      end
   end

   // status flags: a same-cycle event beats the read clear
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         rx_status_reg <= 7'h00;
         timer_status_reg <= 4'h0;
         modem_delta_reg <= 4'h0;
         rx_fifo_request_ack_reg <= 1'b0;
      end else begin
         // line status and rx status reads clear the same flops
         rx_status_reg <= (rx_status_reg & ~{7{rd_line | rd_rxst}}) | rx_set;
         // expiry sticky; gate bits mirror only
         timer_status_reg[1:0] <= (timer_status_reg[1:0] & ~{2{rd_timer_status}}) |
                                  {i_timer_b_tc, i_timer_a_tc};
         timer_status_reg[3:2] <= {i_gate_b_state, i_gate_a_state};
         modem_delta_reg <= (modem_delta_reg & ~{4{rd_mdst}}) | mdm_set;
         // ack lasts until the level drops to the threshold or below
         if (!rx_above) begin
            rx_fifo_request_ack_reg <= 1'b0;
         end else if (rx_fifo_request_ack_wr) begin
            rx_fifo_request_ack_reg <= 1'b1;
         end
      end
   end

   // per-character flags load together with the data register
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         char_flags_reg <= 7'h00;
      end else if (i_char_load) begin
         char_flags_reg[0] <= ~i_char_frame_err & (i_sw_parity_mode | ~i_char_parity_err);
         char_flags_reg[1] <= i_sample_16x & i_char_noisy;
         char_flags_reg[2] <= i_sw_parity_mode ? i_char_parity_bit : i_char_parity_err;
         char_flags_reg[3] <= ctl_seen;
         char_flags_reg[4] <= frame_flag;
         char_flags_reg[5] <= i_char_len9 & i_char_data[8];
         char_flags_reg[6] <= i_char_break;
      end
   end

   // modem pin synchroniser and history
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         mdm_s1_reg <= 4'hF;
         mdm_s2_reg <= 4'hF;
         mdm_prev_reg <= 4'hF;
      end else begin
         mdm_s1_reg <= {i_dcd_pin, i_ri_pin, i_dsr_pin, i_cts_pin};
         mdm_s2_reg <= mdm_s1_reg;
         mdm_prev_reg <= mdm_s2_reg;
      end
   end

   // stage one: request register, stage two: enabled copy, stage three: code and pin
   // code and pin trail the request register by two clocks and long paths are broken
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         general_block_request_reg <= 6'h00;
         gated_reg <= 6'h00;
         priority_code_reg <= `SSIU_C_MODEM;
         irq_waiting_n_reg <= 1'b1;
         o_irq <= 1'b0;
         tx_hold_reg <= 1'b0;
      end else begin
         general_block_request_reg <= {tim_req, i_tx_idle_state, rxm_req, rx_fifo_request, txf_req, mdm_req};
         gated_reg <= gated;
         // recomputed each clock so a higher source takes over
         priority_code_reg <= code_next;
         irq_waiting_n_reg <= ~(|gated_reg);
         o_irq <= |gated_reg;
         // hold entered on a code read naming the tx fifo
         if (i_tx_char_write || (wr_gen && !w_data_reg[`SSIU_B_TXF])) begin
            tx_hold_reg <= 1'b0;
         end else if (rd_code && !irq_waiting_n_reg && priority_code_reg == `SSIU_C_TXF) begin
            tx_hold_reg <= 1'b1;
         end
      end
   end

endmodule
